// ### rtl/limit_cfg_pkg.sv
// limit_cfg_pkg: constants, codes and carriers shared by the current-limit register bank.
// assumes a 20 MHz system clock and an 8-bit register address space from the serial client.
package limit_cfg_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ           = 20_000_000;
   localparam real         POWERUP_QUIET_MS = 5.5;
   localparam real         WAKE_SETTLE_MS   = 3.0;
   localparam int unsigned POWERUP_CYCLES   = int'(POWERUP_QUIET_MS * CLK_HZ / 1000.0);
   localparam int unsigned WAKE_CYCLES      = int'(WAKE_SETTLE_MS * CLK_HZ / 1000.0);

   // register offsets
   localparam logic [7:0] ADDR_DIVIDER_RATIO = 8'h4c;
   localparam logic [7:0] ADDR_APPLIED_LIMIT = 8'h50;
   localparam logic [7:0] ADDR_CUSTOM_LIMIT  = 8'h51;
   localparam logic [7:0] ADDR_PRODUCT_CODE  = 8'hfd;
   localparam logic [7:0] ADDR_MAKER_CODE    = 8'hfe;
   localparam logic [7:0] ADDR_PART_REVISION = 8'hff;

   // reset values
   localparam logic [2:0] DIVIDER_RATIO_RST = 3'h0;
   localparam logic [7:0] LIMIT_BEHAVIOR_RST = 8'h82;
   // identity codes: arbitrary neutral values
   localparam logic [7:0] PRODUCT_CODE_DFLT  = 8'h11;
   localparam logic [7:0] MAKER_CODE_DFLT    = 8'h22;
   localparam logic [7:0] PART_REVISION_DFLT = 8'h33;

   // field positions in the limit behavior registers
   localparam int FLOOR_MSB = 7;
   localparam int FLOOR_LSB = 6;
   localparam int IMIN_MSB  = 4;
   localparam int IMIN_LSB  = 2;
   localparam int RSVD_MSB  = 1;
   localparam int RSVD_LSB  = 0;
   localparam logic [7:0] LIMIT_IMPL_MASK = 8'hdf;

   // codes
   localparam logic [2:0] RATIO_NOT_USED = 3'h7;
   localparam logic [3:0] RESP_DIV_DP    = 4'h6;
   localparam logic [3:0] RESP_DIV_DM    = 4'h9;
   localparam logic [3:0] RESP_DIV_BOTH  = 4'hc;
   localparam logic [11:0] TRIP_ABOVE_MA = 12'd1680;

   typedef enum logic [2:0] {
      prof_bc12_cdp, prof_bc12_dcp, prof_legacy_other, prof_legacy3,
      prof_custom, prof_no_handshake
   } profile_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   typedef struct packed {
      logic [1:0] bus_voltage_floor;
      logic [2:0] min_current_threshold;
      logic       trip_mode;
   } limit_cfg_s;

   // min-current threshold code to mA (typical)
   function automatic logic [11:0] imin_to_ma(input logic [2:0] code);
      unique case (code)
         3'h0: imin_to_ma = 12'd120;
         3'h1: imin_to_ma = 12'd570;
         3'h2: imin_to_ma = 12'd1000;
         3'h3: imin_to_ma = 12'd1350;
         3'h4: imin_to_ma = 12'd1680;
         default: imin_to_ma = 12'd2050;
      endcase
   endfunction

   // strap step to current limit in mA (typical)
   function automatic logic [11:0] step_to_ma(input logic [2:0] step);
      unique case (step)
         3'h0: step_to_ma = 12'd570;
         3'h1: step_to_ma = 12'd1000;
         3'h2: step_to_ma = 12'd1130;
         3'h3: step_to_ma = 12'd1350;
         3'h4: step_to_ma = 12'd1680;
         3'h5: step_to_ma = 12'd2050;
         3'h6: step_to_ma = 12'd2280;
         default: step_to_ma = 12'd2850;
      endcase
   endfunction

endpackage

// ### rtl/strap_decode.sv
// strap_decode: synchronises the digitised strap level and captures it once after reset.
// assumes the strap code arrives asynchronously from a comparator ladder, 0 = ground.
`timescale 1ns/10ps
`default_nettype none
module strap_decode (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // strap level, ascending resistor order
   input  wire logic [3:0] mode_limit_strap_pin,
   // decoded
   output logic            smbus_mode,
   output logic [2:0]      current_limit_setting,
   output logic            strap_valid
);
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else begin
         sync1_reg <= mode_limit_strap_pin;
         sync2_reg <= sync1_reg;
      end
   end

   // strap caught once, three edges after release, never re-read
   logic [1:0] settle_reg;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         settle_reg            <= 2'h0;
         strap_valid           <= 1'b0;
         smbus_mode            <= 1'b1;
         current_limit_setting <= 3'h0;
      end else if (!strap_valid) begin
         settle_reg <= settle_reg + 2'h1;
         if (settle_reg == 2'h2) begin
            strap_valid <= 1'b1;
            smbus_mode  <= ~sync2_reg[3];
            current_limit_setting <= sync2_reg[2:0];
         end
      end
   end
endmodule // strap_decode
`default_nettype wire

// ### rtl/bus_ready_timer.sv
// bus_ready_timer: gates serial access during the power-up quiet time and sleep wake-up.
// assumes wake_read pulses once per read command addressed to this device.
`timescale 1ns/10ps
`default_nettype none
module bus_ready_timer #(
   parameter int unsigned POWERUP_CYCLES = 110000,
   parameter int unsigned WAKE_CYCLES    = 60000
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // power control
   input  wire logic sleep_req,
   input  wire logic wake_read,
   // status
   output logic      bus_ready,
   output logic      asleep
);
   typedef enum logic [1:0] {st_warmup, st_run, st_sleep, st_waking} ready_state_e;
   ready_state_e state_reg;
   logic [16:0]  count_reg;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= st_warmup;
         count_reg <= 17'h0;
      end else begin
         unique case (state_reg)
            st_warmup: begin
               count_reg <= count_reg + 17'h1;
               if (count_reg == 17'(POWERUP_CYCLES - 1)) begin
                  state_reg <= st_run;
               end
            end
            st_run: begin
               count_reg <= 17'h0;
               if (sleep_req) begin
                  state_reg <= st_sleep;
               end
            end
            st_sleep: begin
               if (wake_read) begin
                  state_reg <= st_waking;
               end
            end
            st_waking: begin
               count_reg <= count_reg + 17'h1;
               if (count_reg == 17'(WAKE_CYCLES - 1)) begin
                  state_reg <= st_run;
               end
            end
         endcase
      end
   end

   assign bus_ready = (state_reg == st_run);
   assign asleep    = (state_reg == st_sleep) || (state_reg == st_waking);
endmodule // bus_ready_timer
`default_nettype wire

// ### rtl/current_limit_config_regs.sv
// current_limit_config_regs: divider ratio, applied and custom limit behavior, identity registers.
// assumes a serial client delivers one-cycle register read/write strobes on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module current_limit_config_regs
   import limit_cfg_pkg::*;
#(
   parameter int unsigned POWERUP_CYCLES = limit_cfg_pkg::POWERUP_CYCLES,
   parameter int unsigned WAKE_CYCLES    = limit_cfg_pkg::WAKE_CYCLES,
   parameter logic [7:0]  PRODUCT_CODE   = limit_cfg_pkg::PRODUCT_CODE_DFLT,
   parameter logic [7:0]  MAKER_CODE     = limit_cfg_pkg::MAKER_CODE_DFLT,
   parameter logic [7:0]  PART_REVISION  = limit_cfg_pkg::PART_REVISION_DFLT
) (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      reset,
   // register access from the serial client
   input  wire limit_cfg_pkg::reg_req_s   reg_req,
   input  wire logic                      wake_read,
   output logic [7:0]                     reg_rdata,
   output logic                           reg_rvalid,
   output logic                           reg_ack,
   output logic                           bus_ready,
   // power state
   input  wire logic                      sleep_req,
   output logic                           asleep,
   // strap
   input  wire logic [3:0]                mode_limit_strap_pin,
   output logic                           smbus_mode,
   output logic [2:0]                     current_limit_setting,
   // emulation cycle
   input  wire logic                      emulation_done,
   input  wire limit_cfg_pkg::profile_e   emulation_profile,
   input  wire logic [3:0]                stimulus_response_sel,
   input  wire logic [1:0]                profile_bus_voltage_floor,
   input  wire logic [2:0]                profile_min_current_threshold,
   // applied behavior to the analog core
   output limit_cfg_pkg::limit_cfg_s      limit_cfg,
   output logic                           divider_en,
   output logic [2:0]                     divider_ratio_sel
);
   import limit_cfg_pkg::*;

   logic       strap_valid;
   logic [2:0] ratio_reg;
   logic [7:0] applied_reg;
   logic [7:0] custom_reg;
   logic       custom_used_reg;
   logic       wr_ok;
   logic       rd_ok;

   strap_decode u_strap (
      .clk_sys               (clk_sys),
      .reset                 (reset),
      .mode_limit_strap_pin  (mode_limit_strap_pin),
      .smbus_mode            (smbus_mode),
      .current_limit_setting (current_limit_setting),
      .strap_valid           (strap_valid)
   );

   bus_ready_timer #(
      .POWERUP_CYCLES (POWERUP_CYCLES),
      .WAKE_CYCLES    (WAKE_CYCLES)
   ) u_ready (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .sleep_req (sleep_req),
      .wake_read (wake_read),
      .bus_ready (bus_ready),
      .asleep    (asleep)
   );

   // nothing is serviced before ready; stand-alone mode has no serial access
   // writes while asleep or waking are dropped
   assign wr_ok = reg_req.wr && bus_ready && smbus_mode && strap_valid;
   assign rd_ok = reg_req.rd && smbus_mode && strap_valid && (bus_ready || asleep);

   // custom register: software writes, unaffected by sleep
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         custom_reg <= LIMIT_BEHAVIOR_RST;
      // only reset or a write changes it
      end else if (wr_ok && reg_req.addr == ADDR_CUSTOM_LIMIT) begin
         // reserved bits taken as written; host keeps them at power-on value
         custom_reg <= reg_req.wdata & LIMIT_IMPL_MASK;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ratio_reg <= DIVIDER_RATIO_RST;
      end else if (wr_ok && reg_req.addr == ADDR_DIVIDER_RATIO) begin
         ratio_reg <= reg_req.wdata[2:0];
      end
   end

   // which settings the last emulation cycle selected
   logic custom_cond;
   // legacy other than 3, custom profile, or a device that never handshook
   assign custom_cond = (emulation_profile == prof_legacy_other) ||
                        (emulation_profile == prof_custom) ||
                        (emulation_profile == prof_no_handshake);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         applied_reg     <= LIMIT_BEHAVIOR_RST;
         custom_used_reg <= 1'b0;
      end else if (emulation_done) begin
         custom_used_reg <= custom_cond;
         // refresh applied values when custom ones are not used
         if (!custom_cond) begin
            applied_reg <= {profile_bus_voltage_floor, 1'b0,
                            profile_min_current_threshold,
                            LIMIT_BEHAVIOR_RST[RSVD_MSB:RSVD_LSB]};
         end
      end
   end

   // divider ratio applied to the legacy stimulus
   logic is_divider_resp;
   logic is_legacy;
   assign is_divider_resp = (stimulus_response_sel == RESP_DIV_DP) ||
                            (stimulus_response_sel == RESP_DIV_DM) ||
                            (stimulus_response_sel == RESP_DIV_BOTH);
   assign is_legacy = (emulation_profile == prof_legacy_other) ||
                      (emulation_profile == prof_legacy3);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         divider_en        <= 1'b0;
         divider_ratio_sel <= DIVIDER_RATIO_RST;
      // BC1.2 profiles leave the applied divider untouched
      end else if (emulation_done && is_legacy) begin
         // only divider responses, never the unused code
         divider_en <= is_divider_resp && (ratio_reg != RATIO_NOT_USED);
         if (is_divider_resp && ratio_reg != RATIO_NOT_USED) begin
            divider_ratio_sel <= ratio_reg;
         end
      end
   end

   // current-limit behavior to the analog core
   logic [7:0]  sel_reg_value;
   logic [11:0] imin_ma;
   logic [11:0] limit_ma;
   logic        trip_next;

   assign sel_reg_value = custom_used_reg ? custom_reg : applied_reg;
   assign imin_ma = imin_to_ma(sel_reg_value[IMIN_MSB:IMIN_LSB]);
   assign limit_ma = step_to_ma(current_limit_setting);
   assign trip_next = !custom_used_reg || (imin_ma <= limit_ma) || (limit_ma > TRIP_ABOVE_MA);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         limit_cfg <= '{bus_voltage_floor:     LIMIT_BEHAVIOR_RST[FLOOR_MSB:FLOOR_LSB],
                        min_current_threshold: LIMIT_BEHAVIOR_RST[IMIN_MSB:IMIN_LSB],
                        trip_mode:             1'b1};
      end else begin
         // floor is passed on in either mode so it is always checked
         limit_cfg.bus_voltage_floor     <= sel_reg_value[FLOOR_MSB:FLOOR_LSB];
         limit_cfg.min_current_threshold <= sel_reg_value[IMIN_MSB:IMIN_LSB];
         limit_cfg.trip_mode             <= trip_next;
      end
   end

   // read mux
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_req.addr)
         ADDR_DIVIDER_RATIO: rd_mux = {5'h00, ratio_reg};
         ADDR_APPLIED_LIMIT: rd_mux = applied_reg & LIMIT_IMPL_MASK;
         ADDR_CUSTOM_LIMIT:  rd_mux = custom_reg & LIMIT_IMPL_MASK;
         ADDR_PRODUCT_CODE:  rd_mux = PRODUCT_CODE;
         ADDR_MAKER_CODE:    rd_mux = MAKER_CODE;
         ADDR_PART_REVISION: rd_mux = PART_REVISION;
         default:            rd_mux = 8'h00;
      endcase
   end

   // answers one edge after the strobe; read-only targets still ack but keep content
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
         reg_ack    <= 1'b0;
      end else begin
         reg_ack    <= wr_ok || rd_ok;
         reg_rvalid <= rd_ok && bus_ready;
         if (rd_ok) begin
            // data for the waking read is zero and flagged invalid
            reg_rdata <= bus_ready ? rd_mux : 8'h00;
         end
      end
   end
endmodule // current_limit_config_regs
`default_nettype wire

// ### sim/current_limit_config_regs_props.sv
// current_limit_config_regs_props: port-level checks for the limit register bank.
// assumes one clock domain and a strap that stays put between resets.
`timescale 1ns/10ps
`default_nettype none
module current_limit_config_regs_props
   import limit_cfg_pkg::*;
(
   // clock and reset
   input wire logic                      clk_sys,
   input wire logic                      reset,
   // register access
   input wire limit_cfg_pkg::reg_req_s   reg_req,
   input wire logic                      wake_read,
   input wire logic [7:0]                reg_rdata,
   input wire logic                      reg_rvalid,
   input wire logic                      reg_ack,
   input wire logic                      bus_ready,
   // power and strap
   input wire logic                      sleep_req,
   input wire logic                      asleep,
   input wire logic [3:0]                mode_limit_strap_pin,
   input wire logic                      smbus_mode,
   input wire logic [2:0]                current_limit_setting,
   // emulation and applied behavior
   input wire logic                      emulation_done,
   input wire limit_cfg_pkg::profile_e   emulation_profile,
   input wire logic [3:0]                stimulus_response_sel,
   input wire logic [1:0]                profile_bus_voltage_floor,
   input wire logic [2:0]                profile_min_current_threshold,
   input wire limit_cfg_pkg::limit_cfg_s limit_cfg,
   input wire logic                      divider_en,
   input wire logic [2:0]                divider_ratio_sel
);
   logic cust_p, bc_p, leg_p, div_c;
   assign cust_p = emulation_profile inside {prof_legacy_other, prof_custom, prof_no_handshake};
   assign bc_p   = emulation_profile inside {prof_bc12_cdp, prof_bc12_dcp};
   assign leg_p  = emulation_profile inside {prof_legacy_other, prof_legacy3};
   assign div_c  = stimulus_response_sel inside {RESP_DIV_DP, RESP_DIV_DM, RESP_DIV_BOTH};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   chk_quiet_noack: assert property (
      (reg_req.wr || reg_req.rd) && !bus_ready && !asleep |=> !reg_ack)
      else $error("access answered before ready");
   chk_standalone_quiet: assert property (!smbus_mode |=> !reg_ack)
      else $error("access answered in stand-alone mode");
   chk_ack_cause: assert property (reg_ack |-> $past(reg_req.wr || reg_req.rd))
      else $error("ack without a request");
   chk_sleep_wr_drop: assert property (asleep && reg_req.wr |=> !reg_ack)
      else $error("write taken while asleep");
   chk_sleep_enter: assert property (
      bus_ready && sleep_req |=> asleep && !bus_ready)
      else $error("sleep request not taken");
   chk_wake_rd_invalid: assert property (
      smbus_mode && asleep && reg_req.rd |=> reg_ack && !reg_rvalid && reg_rdata == 8'h00)
      else $error("waking read not flagged invalid");
   chk_read_served: assert property (
      smbus_mode && bus_ready && !asleep && reg_req.rd |=> reg_ack && reg_rvalid)
      else $error("ready read not served");
   chk_fixed_apply: assert property (
      emulation_done && !cust_p |-> ##2 (limit_cfg.trip_mode
         && limit_cfg.bus_voltage_floor == $past(profile_bus_voltage_floor, 2)
         && limit_cfg.min_current_threshold == $past(profile_min_current_threshold, 2)))
      else $error("applied behavior not taken from profile");
   chk_high_limit_trip: assert property (
      emulation_done && cust_p && current_limit_setting > 3'h4 |-> ##2 limit_cfg.trip_mode)
      else $error("limit above 1680 mA without trip");
   chk_bc_div_hold: assert property (
      emulation_done && bc_p |=> $stable(divider_en) && $stable(divider_ratio_sel))
      else $error("divider changed by a BC1.2 profile");
   chk_div_code_only: assert property (
      emulation_done && leg_p && !div_c |=> !divider_en)
      else $error("divider enabled for a non-divider response");
   chk_ratio_never7: assert property (divider_en |-> divider_ratio_sel != RATIO_NOT_USED)
      else $error("divider ratio 7 applied");
   chk_strap_map: assert property (
      bus_ready |-> smbus_mode == !mode_limit_strap_pin[3]
         && current_limit_setting == mode_limit_strap_pin[2:0])
      else $error("strap decode wrong");
endmodule // current_limit_config_regs_props
bind current_limit_config_regs current_limit_config_regs_props u_props (
   .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .wake_read(wake_read),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_ack(reg_ack), .bus_ready(bus_ready),
   .sleep_req(sleep_req), .asleep(asleep), .mode_limit_strap_pin(mode_limit_strap_pin),
   .smbus_mode(smbus_mode), .current_limit_setting(current_limit_setting),
   .emulation_done(emulation_done), .emulation_profile(emulation_profile),
   .stimulus_response_sel(stimulus_response_sel),
   .profile_bus_voltage_floor(profile_bus_voltage_floor),
   .profile_min_current_threshold(profile_min_current_threshold),
   .limit_cfg(limit_cfg), .divider_en(divider_en), .divider_ratio_sel(divider_ratio_sel)
);
`default_nettype wire

// ### sim/limit_host_model.sv
// limit_host_model: serial host stand-in issuing one-cycle register strobes.
// assumes the bench calls acc and wait_ready hierarchically.
`timescale 1ns/10ps
`default_nettype none
module limit_host_model
   import limit_cfg_pkg::*;
(
   // clock and status
   input  wire logic                   clk_sys,
   input  wire logic                   bus_ready,
   // request to the register bank
   output var limit_cfg_pkg::reg_req_s reg_req
);
   initial reg_req = '0;
   task automatic wait_ready();
      for (int k = 0; k < 200 && bus_ready !== 1'b1; k++) begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
      logic [7:0] dd;
      dd = d;
      if (w && a == ADDR_CUSTOM_LIMIT) begin
         dd[1:0] = LIMIT_BEHAVIOR_RST[1:0];
      end
      @(posedge clk_sys);
      #1;
      reg_req = '{addr: a, wdata: dd, wr: w, rd: !w};
      @(posedge clk_sys);
      #1;
      // a stale address must not look like a live one
      reg_req = '{addr: ~a, wdata: ~dd, wr: 1'b0, rd: 1'b0};
      repeat (2) @(posedge clk_sys);
   endtask
endmodule // limit_host_model
`default_nettype wire

// ### sim/current_limit_config_regs_tb_top.sv
// current_limit_config_regs_tb_top: self-checking bench for the limit register bank.
// assumes shortened quiet and wake counts; expected reads wait in a queue.
`timescale 1ns/10ps
`default_nettype none
module current_limit_config_regs_tb_top;
   import limit_cfg_pkg::*;
   logic       clk_sys, reset, wake_read, sleep_req, emulation_done;
   logic       reg_rvalid, reg_ack, bus_ready, asleep, smbus_mode, divider_en;
   logic [3:0] strap, resp_sel;
   logic [1:0] p_floor;
   logic [2:0] p_imin, cur_lim, div_sel;
   logic [7:0] reg_rdata;
   logic [8:0] e_note;
   reg_req_s   reg_req;
   profile_e   prof;
   limit_cfg_s limit_cfg;
   int         num_errors = 0;
   int         checked = 0;
   logic [8:0] notes[$];
   int unsigned imin_ma[6] = '{120, 570, 1000, 1350, 1680, 2050};
   int unsigned lim_ma[8] = '{570, 1000, 1130, 1350, 1680, 2050, 2280, 2850};
   current_limit_config_regs #(.POWERUP_CYCLES(20), .WAKE_CYCLES(10)) dut (
      .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .wake_read(wake_read),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_ack(reg_ack), .bus_ready(bus_ready),
      .sleep_req(sleep_req), .asleep(asleep), .mode_limit_strap_pin(strap),
      .smbus_mode(smbus_mode), .current_limit_setting(cur_lim),
      .emulation_done(emulation_done), .emulation_profile(prof), .stimulus_response_sel(resp_sel),
      .profile_bus_voltage_floor(p_floor), .profile_min_current_threshold(p_imin),
      .limit_cfg(limit_cfg), .divider_en(divider_en), .divider_ratio_sel(div_sel));
   limit_host_model host (.clk_sys(clk_sys), .bus_ready(bus_ready), .reg_req(reg_req));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (num_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      notes.push_back({1'b1, e});
      host.acc(a, 8'h00, 1'b0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      notes.push_back(9'h000);
      host.acc(a, d, 1'b1);
   endtask
   always @(posedge clk_sys) begin
      #2;
      if (reg_ack === 1'b1) begin
         if (notes.size() == 0) begin
            chk(8'h01, 8'h00);
         end else begin
            e_note = notes.pop_front();
            chk({7'h0, reg_rvalid}, {7'h0, e_note[8]});
            if (e_note[8]) begin
               chk(reg_rdata, e_note[7:0]);
            end
         end
      end
   end
   task automatic emulate(input int p, input logic [2:0] r, input logic [7:0] c);
      logic [3:0] codes[4];
      logic [1:0] f;
      logic [2:0] i, ps;
      logic       pe, tr, en;
      codes = '{4'h6, 4'h9, 4'hc, 4'($urandom % 16)};
      f = 2'($urandom % 4);
      i = 3'($urandom % 6);
      pe = divider_en;
      ps = div_sel;
      @(posedge clk_sys);
      #1;
      prof = profile_e'(p);
      resp_sel = codes[$urandom % 4];
      p_floor = f;
      p_imin = i;
      emulation_done = 1'b1;
      @(posedge clk_sys);
      #1;
      emulation_done = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      tr = imin_ma[c[4:2]] <= lim_ma[strap[2:0]] || lim_ma[strap[2:0]] > 1680;
      if (prof inside {prof_legacy_other, prof_custom, prof_no_handshake}) begin
         chk({2'h0, limit_cfg}, {2'h0, c[7:6], c[4:2], tr});
      end else begin
         chk({2'h0, limit_cfg}, {2'h0, f, i, 1'b1});
         rd(ADDR_APPLIED_LIMIT, {f, 1'b0, i, LIMIT_BEHAVIOR_RST[1:0]});
      end
      if (prof inside {prof_bc12_cdp, prof_bc12_dcp}) begin
         chk({4'h0, divider_en, div_sel}, {4'h0, pe, ps});
      end
      if (prof inside {prof_legacy_other, prof_legacy3}) begin
         en = resp_sel inside {4'h6, 4'h9, 4'hc} && r != 3'h7;
         chk({7'h0, divider_en}, {7'h0, en});
         if (en) begin
            chk({5'h0, div_sel}, {5'h0, r});
         end
      end
   endtask
   task automatic run(input logic [3:0] s);
      logic [7:0] ad[7], ev[7], c;
      logic [2:0] r;
      ad = '{ADDR_DIVIDER_RATIO, ADDR_APPLIED_LIMIT, ADDR_CUSTOM_LIMIT, ADDR_PRODUCT_CODE,
             ADDR_MAKER_CODE, ADDR_PART_REVISION, 8'h4d};
      ev = '{8'h00, LIMIT_BEHAVIOR_RST, LIMIT_BEHAVIOR_RST, PRODUCT_CODE_DFLT,
             MAKER_CODE_DFLT, PART_REVISION_DFLT, 8'h00};
      // reset and strap move off the clock edge, never in its time step
      @(posedge clk_sys);
      #1;
      strap = s;
      reset = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      chk({2'h0, limit_cfg}, {2'h0, 2'h2, 3'h0, 1'b1});
      host.acc(ADDR_PRODUCT_CODE, 8'h00, 1'b0);
      chk({7'h0, bus_ready}, 8'h00);
      host.wait_ready();
      chk({7'h0, bus_ready}, 8'h01);
      chk({4'h0, smbus_mode, cur_lim}, {4'h0, ~s[3], s[2:0]});
      if (s[3]) begin
         host.acc(ADDR_PRODUCT_CODE, 8'h00, 1'b0);
         return;
      end
      for (int k = 0; k < 7; k++) begin
         rd(ad[k], ev[k]);
      end
      for (int k = 1; k < 6; k++) begin
         if (k != 2) begin
            wr(ad[k], 8'($urandom));
         end
      end
      for (int k = 0; k < 7; k++) begin
         rd(ad[k], ev[k]);
      end
      repeat (12) begin
         r = 3'($urandom % 8);
         c = {2'($urandom % 4), 1'b0, 3'($urandom % 6), LIMIT_BEHAVIOR_RST[1:0]};
         wr(ADDR_DIVIDER_RATIO, {5'($urandom), r});
         rd(ADDR_DIVIDER_RATIO, {5'h00, r});
         wr(ADDR_CUSTOM_LIMIT, c | 8'h20);
         rd(ADDR_CUSTOM_LIMIT, c);
         for (int p = 0; p < 6; p++) begin
            emulate(p, r, c);
         end
      end
      @(posedge clk_sys);
      #1;
      sleep_req = 1'b1;
      for (int k = 0; k < 50 && asleep !== 1'b1; k++) begin
         @(posedge clk_sys);
         #1;
      end
      sleep_req = 1'b0;
      chk({7'h0, asleep}, 8'h01);
      host.acc(ADDR_CUSTOM_LIMIT, ~c, 1'b1);
      notes.push_back(9'h000);
      fork
         host.acc(ADDR_CUSTOM_LIMIT, 8'h00, 1'b0);
         begin
            @(posedge clk_sys);
            #1 wake_read = 1'b1;
            @(posedge clk_sys);
            #1 wake_read = 1'b0;
         end
      join
      #1;
      chk({7'h0, bus_ready}, 8'h00);
      host.wait_ready();
      chk({7'h0, bus_ready}, 8'h01);
      rd(ADDR_CUSTOM_LIMIT, c);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      {reset, wake_read, sleep_req, emulation_done} = 4'h8;
      {strap, resp_sel, p_floor, p_imin} = '0;
      prof = prof_bc12_cdp;
      void'($urandom(63481));
      run({1'b0, 3'(5 + $urandom % 3)});
      run(4'h4);
      run({1'b1, 3'($urandom % 8)});
      end_sim();
   end
   initial begin
      #2_000_000;
      num_errors++;
      end_sim();
   end
endmodule // current_limit_config_regs_tb_top
`default_nettype wire
